// [design/tsc_consts.svh]
// Offsets, field positions, reset values and timing counts of the state control block
`ifndef TSC_CONSTS_SVH
`define TSC_CONSTS_SVH
`define TSC_MR_COUNT 24
`define TSC_MR_SAVE_LAST 15
`define TSC_MR_DEBUG 16
`define TSC_MR_DRTM 17
`define TSC_MR_DYN_FIRST 18
`define TSC_MR_ONES_LAST 22
`define TSC_MR_RST_FIRST 20
`define TSC_MR_APP 23
`define TSC_ADR_STATUS 8'h00
`define TSC_ADR_MR_SEL 8'h04
`define TSC_ADR_MR_DATA 8'h08
`define TSC_ADR_TEST 8'h0C
`define TSC_ST_PWR 0
`define TSC_ST_LP 1
`define TSC_ST_STARTED 2
`define TSC_ST_SAVED 3
`define TSC_ST_LPC_PM 4
`define TSC_ST_TBUSY 5
`define TSC_ST_TFAIL 6
`define TSC_ST_TDONE 7
`define TSC_SEL_WORD 8
`define TSC_MR_SEL_RESET 32'h0000_0000
`define TSC_RC_SUCCESS 8'h00
`define TSC_RC_FAILURE 8'h01
`define TSC_RC_RESTORE_FAIL 8'h02
`define TSC_RC_NEEDS_TEST 8'h03
`define TSC_RC_TESTING 8'h0A
`define TSC_CLK_MHZ 50
`define TSC_TIMEOUT_B_US 1000
`define TSC_TEST_CYCLES 16
`define TSC_TEST_COUNT 8
`endif

// [design/tsc_pkg.sv]
// Types shared by the state control block
package tsc_pkg;
	typedef enum logic [2:0] {
		TSC_CMD_STARTUP,
		TSC_CMD_SHUTDOWN,
		TSC_CMD_MR_RESET,
		TSC_CMD_SELF_TEST,
		TSC_CMD_TEST_QUERY,
		TSC_CMD_OTHER
	} tsc_cmd_e;
	typedef enum logic {
		TSC_PWR_FULL,
		TSC_PWR_OFF
	} tsc_pwr_e;
	typedef logic [7:0] tsc_rc_t;
endpackage

// [design/tsc_self_test.sv]
// Background and full self-test sequencer
`timescale 1ns/1ps
`default_nettype none
`include "tsc_consts.svh"
module tsc_self_test #(
	parameter int TEST_COUNT = `TSC_TEST_COUNT,
	parameter int TEST_CYCLES = `TSC_TEST_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic clear,
	input wire logic start_bg,
	input wire logic start_full,
	input wire logic fault,
	output logic busy,
	output logic all_done,
	output logic failed,
	output logic done
);
	logic [$clog2(TEST_COUNT+1)-1:0] tested;
	logic [$clog2(TEST_CYCLES+1)-1:0] cyc;
	logic last;

	initial begin
		if (TEST_COUNT < 1 || TEST_CYCLES < 1)
			$error("tsc_self_test: counts must be positive");
	end

	assign last = (cyc == ($bits(cyc))'(TEST_CYCLES - 1));
	assign all_done = (tested == ($bits(tested))'(TEST_COUNT));

	// Full run restarts from the first test so every function is covered
	always_ff @(posedge clk) begin
		if (rst || clear) begin
			tested <= '0;
			cyc <= '0;
			busy <= 1'b0;
			failed <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start_full) begin
				tested <= '0;
				cyc <= '0;
				busy <= 1'b1;
				failed <= 1'b0;
			end else if (start_bg && !all_done) begin
				busy <= 1'b1;
			end else if (busy) begin
				if (fault)
					failed <= 1'b1;
				cyc <= last ? '0 : cyc + 1'b1;
				if (last) begin
					tested <= tested + 1'b1;
					if (tested == ($bits(tested))'(TEST_COUNT - 1)) begin
						busy <= 1'b0;
						done <= 1'b1;
					end
				end
			end
		end
	end

	done_count_a: assert property (@(posedge clk) disable iff (rst)
		done |-> all_done && !busy)
		else $error("test completion without all tests run");
endmodule // tsc_self_test
`default_nettype wire

// [design/tsc_state_ctrl.sv]
// Measurement register, power state, saved state and self-test control with Wishbone slave
//
// Added by the designer: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tsc_consts.svh"
module tsc_state_ctrl
	import tsc_pkg::*;
#(
	parameter int DIGEST_W = 256,
	parameter bit LPC_BUS = 1'b0,
	parameter bit SPI_BUS = 1'b1,
	parameter int TIMEOUT_B_CYC = `TSC_TIMEOUT_B_US * `TSC_CLK_MHZ,
	parameter int TEST_COUNT = `TSC_TEST_COUNT,
	parameter int TEST_CYCLES = `TSC_TEST_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic device_init_indication,
	input wire logic power_loss,
	input wire logic bus_power_down_pin,
	input wire logic iface_idle,
	input wire logic ready_req,
	output logic ready_ack,
	output logic core_gate,
	output logic lpc_pm_enabled,
	input wire logic hw_root_done,
	input wire logic [DIGEST_W-1:0] hw_root_value,
	input wire logic drtm_end,
	input wire logic [DIGEST_W-1:0] drtm_value,
	input wire logic test_fault,
	input wire logic cmd_valid,
	input wire tsc_pkg::tsc_cmd_e cmd_kind,
	input wire logic cmd_flag,
	input wire logic cmd_alters_state,
	input wire logic [2:0] cmd_locality,
	output logic cmd_ready,
	output logic resp_valid,
	output tsc_pkg::tsc_rc_t resp_code
);
	import tsc_pkg::*;
	localparam int WORDS = DIGEST_W / 32;

	logic [DIGEST_W-1:0] mr [`TSC_MR_COUNT];
	logic [DIGEST_W-1:0] saved [`TSC_MR_SAVE_LAST+1];
	tsc_pwr_e pwr;
	logic lp, started, saved_valid, root_seen, strap_pend, pend_full;
	logic [31:0] mr_sel;
	logic take, take_startup, take_shutdown, take_reset, take_test, take_query;
	logic st_busy, st_all_done, st_failed, st_done, wake, next_lp;
	logic wb_req;
	tsc_rc_t test_status;

	initial begin
		if (DIGEST_W < 32 || DIGEST_W % 32 != 0)
			$error("tsc_state_ctrl: DIGEST_W must be a multiple of 32");
		if (TIMEOUT_B_CYC < 2)
			$error("tsc_state_ctrl: ready-exit timeout shorter than wake latency");
		if (LPC_BUS && SPI_BUS)
			$error("tsc_state_ctrl: only one bus variant");
	end

	function automatic logic in_range(input int idx, input int lo, input int hi);
		return idx >= lo && idx <= hi;
	endfunction

	function automatic logic [DIGEST_W-1:0] clear_value(input int idx);
		return in_range(idx, `TSC_MR_DRTM, `TSC_MR_ONES_LAST) ? '1 : '0;
	endfunction

	// Decoded command handshake; refused while off or gated
	assign cmd_ready = (pwr == TSC_PWR_FULL) && !lp && !pend_full;
	assign take = cmd_valid && cmd_ready;
	assign take_startup = take && cmd_kind == TSC_CMD_STARTUP;
	assign take_shutdown = take && cmd_kind == TSC_CMD_SHUTDOWN;
	assign take_reset = take && cmd_kind == TSC_CMD_MR_RESET;
	assign take_test = take && cmd_kind == TSC_CMD_SELF_TEST;
	assign take_query = take && cmd_kind == TSC_CMD_TEST_QUERY;

	tsc_self_test #(
		.TEST_COUNT(TEST_COUNT),
		.TEST_CYCLES(TEST_CYCLES)
	) u_test (
		.clk(clk),
		.rst(rst),
		.clear(device_init_indication),
		.start_bg(take_test && !cmd_flag),
		.start_full(take_test && cmd_flag),
		.fault(test_fault),
		.busy(st_busy),
		.all_done(st_all_done),
		.failed(st_failed),
		.done(st_done)
	);

	always_comb begin
		if (st_failed)
			test_status = `TSC_RC_FAILURE;
		else if (st_busy)
			test_status = `TSC_RC_TESTING;
		else if (!st_all_done)
			test_status = `TSC_RC_NEEDS_TEST;
		else
			test_status = `TSC_RC_SUCCESS;
	end

	// Measurement registers; dynamic end is applied last so it wins a same-cycle startup
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < `TSC_MR_COUNT; i++)
				mr[i] <= '0;
		end else begin
			if (hw_root_done)
				mr[0] <= hw_root_value;
			if (take_startup) begin
				for (int i = 0; i < `TSC_MR_COUNT; i++) begin
					if (i == 0) begin
						if (cmd_flag && saved_valid)
							mr[i] <= saved[i];
						else if (!cmd_flag && !root_seen)
							mr[i] <= DIGEST_W'(cmd_locality);
					end else if (i <= `TSC_MR_SAVE_LAST && cmd_flag) begin
						if (saved_valid)
							mr[i] <= saved[i];
					end else begin
						mr[i] <= clear_value(i);
					end
				end
			end
			if (take_reset) begin
				for (int i = 0; i < `TSC_MR_COUNT; i++)
					if (i == `TSC_MR_DEBUG || i == `TSC_MR_APP ||
						in_range(i, `TSC_MR_RST_FIRST, `TSC_MR_ONES_LAST))
						mr[i] <= '0;
			end
			if (drtm_end) begin
				mr[`TSC_MR_DRTM] <= drtm_value;
				for (int i = `TSC_MR_DYN_FIRST; i <= `TSC_MR_ONES_LAST; i++)
					mr[i] <= '0;
			end
		end
	end

	// Root sequence seen since init decides register 0; set wins over init
	always_ff @(posedge clk) begin
		if (rst)
			root_seen <= 1'b0;
		else if (hw_root_done)
			root_seen <= 1'b1;
		else if (device_init_indication)
			root_seen <= 1'b0;
	end

	// Saved state; set wins over void in the shutdown cycle itself
	always_ff @(posedge clk) begin
		if (rst) begin
			saved_valid <= 1'b0;
			for (int i = 0; i <= `TSC_MR_SAVE_LAST; i++)
				saved[i] <= '0;
		end else if (take_shutdown && cmd_flag) begin
			saved_valid <= 1'b1;
			for (int i = 0; i <= `TSC_MR_SAVE_LAST; i++)
				saved[i] <= mr[i];
		end else if (take_shutdown || (take && cmd_alters_state) || take_startup) begin
			saved_valid <= 1'b0;
		end
	end

	// Device power state; shutdown deliberately absent so it never moves the state
	always_ff @(posedge clk) begin
		if (rst || device_init_indication)
			pwr <= TSC_PWR_FULL;
		else if (power_loss)
			pwr <= TSC_PWR_OFF;
	end

	always_ff @(posedge clk) begin
		if (rst)
			started <= 1'b0;
		else if (take_startup)
			started <= 1'b1;
		else if (device_init_indication)
			started <= 1'b0;
	end

	// Low power is entered on interface idle with no self-test busy or pending, and left on interface activity, no host bit
	assign wake = ready_req || cmd_valid || !iface_idle;
	always_comb begin
		next_lp = lp;
		if (!SPI_BUS || !started || pwr != TSC_PWR_FULL)
			next_lp = 1'b0;
		else if (wake)
			next_lp = 1'b0;
		else if (iface_idle && !st_busy && !pend_full)
			next_lp = 1'b1;
	end

	always_ff @(posedge clk) begin
		if (rst || device_init_indication)
			lp <= 1'b0;
		else
			lp <= next_lp;
	end

	always_ff @(posedge clk) begin
		if (rst)
			ready_ack <= 1'b0;
		else
			ready_ack <= ready_req && !next_lp && pwr == TSC_PWR_FULL;
	end

	// Only internal blocks gate; the bus slave below never looks at it
	assign core_gate = lp;

	// Strap sampled one edge after reset release or on each init
	always_ff @(posedge clk) begin
		if (rst)
			strap_pend <= 1'b1;
		else
			strap_pend <= device_init_indication;
	end

	always_ff @(posedge clk) begin
		if (rst)
			lpc_pm_enabled <= 1'b0;
		else if (strap_pend)
			lpc_pm_enabled <= LPC_BUS && !bus_power_down_pin;
	end

	// Command answers; a full test holds its answer until the last test ends
	always_ff @(posedge clk) begin
		if (rst || device_init_indication) begin
			resp_valid <= 1'b0;
			resp_code <= `TSC_RC_SUCCESS;
			pend_full <= 1'b0;
		end else begin
			resp_valid <= 1'b0;
			if (pend_full && st_done) begin
				pend_full <= 1'b0;
				resp_valid <= 1'b1;
				resp_code <= st_failed ? `TSC_RC_FAILURE : `TSC_RC_SUCCESS;
			end else if (take_test && cmd_flag) begin
				pend_full <= 1'b1;
			end else if (take_test) begin
				resp_valid <= 1'b1;
				if (st_failed)
					resp_code <= `TSC_RC_FAILURE;
				else
					resp_code <= st_all_done ? `TSC_RC_SUCCESS : `TSC_RC_TESTING;
			end else if (take_query) begin
				resp_valid <= 1'b1;
				resp_code <= test_status;
			end else if (take_startup && cmd_flag) begin
				resp_valid <= 1'b1;
				resp_code <= saved_valid ? `TSC_RC_SUCCESS : `TSC_RC_RESTORE_FAIL;
			end else if (take) begin
				resp_valid <= 1'b1;
				resp_code <= `TSC_RC_SUCCESS;
			end
		end
	end

	// Wishbone slave, always live whatever the power mode
	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

	always_ff @(posedge clk) begin
		if (rst)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= wb_req;
	end

	always_ff @(posedge clk) begin
		if (rst)
			mr_sel <= `TSC_MR_SEL_RESET;
		else if (wb_req && wb_we_i && wb_adr_i == `TSC_ADR_MR_SEL) begin
			for (int b = 0; b < 4; b++)
				if (wb_sel_i[b])
					mr_sel[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			wb_dat_o <= '0;
		else if (wb_req && !wb_we_i) begin
			case (wb_adr_i)
				`TSC_ADR_STATUS: begin
					wb_dat_o <= '0;
					wb_dat_o[`TSC_ST_PWR] <= pwr == TSC_PWR_OFF;
					wb_dat_o[`TSC_ST_LP] <= lp;
					wb_dat_o[`TSC_ST_STARTED] <= started;
					wb_dat_o[`TSC_ST_SAVED] <= saved_valid;
					wb_dat_o[`TSC_ST_LPC_PM] <= lpc_pm_enabled;
					wb_dat_o[`TSC_ST_TBUSY] <= st_busy;
					wb_dat_o[`TSC_ST_TFAIL] <= st_failed;
					wb_dat_o[`TSC_ST_TDONE] <= st_all_done;
				end
				`TSC_ADR_MR_SEL: wb_dat_o <= mr_sel;
				`TSC_ADR_MR_DATA: begin
					if (mr_sel[7:0] < `TSC_MR_COUNT &&
						32'(mr_sel[`TSC_SEL_WORD +: 8]) < 32'(WORDS))
						wb_dat_o <= mr[mr_sel[4:0]][mr_sel[`TSC_SEL_WORD +: 8]*32 +: 32];
					else
						wb_dat_o <= '0;
				end
				`TSC_ADR_TEST: wb_dat_o <= {24'h000000, test_status};
				default: wb_dat_o <= '0;
			endcase
		end
	end

	sequence clear_start_s;
		take_startup && !cmd_flag && !drtm_end;
	endsequence

	loc_init_a: assert property (@(posedge clk) disable iff (rst)
		clear_start_s and !root_seen and !hw_root_done |=>
		mr[0] == DIGEST_W'($past(cmd_locality)))
		else $error("register 0 not set to locality");
	root_keep_a: assert property (@(posedge clk) disable iff (rst)
		clear_start_s and root_seen and !hw_root_done |=> mr[0] == $past(mr[0]))
		else $error("register 0 lost root sequence value");
	clear_ones_a: assert property (@(posedge clk) disable iff (rst)
		clear_start_s |=> mr[17] == '1 && mr[22] == '1)
		else $error("dynamic registers not all ones after clear");
	clear_zero_a: assert property (@(posedge clk) disable iff (rst)
		clear_start_s and !take_reset |=> mr[1] == '0 && mr[16] == '0 && mr[23] == '0)
		else $error("static registers not zero after clear");
	drtm_load_a: assert property (@(posedge clk) disable iff (rst)
		drtm_end && !take && !hw_root_done |=> mr[17] == $past(drtm_value) &&
		mr[18] == '0 && mr[22] == '0 && $stable(mr[0]) && $stable(mr[23]))
		else $error("dynamic end values wrong");
	mr_reset_a: assert property (@(posedge clk) disable iff (rst)
		take_reset && !drtm_end && !hw_root_done |=> mr[16] == '0 && mr[20] == '0 &&
		mr[23] == '0 && $stable(mr[17]) && $stable(mr[0]))
		else $error("reset command touched wrong registers");
	init_full_a: assert property (@(posedge clk) disable iff (rst)
		device_init_indication |=> pwr == TSC_PWR_FULL && !lp)
		else $error("not at full power after init");
	refuse_a: assert property (@(posedge clk) disable iff (rst)
		pwr != TSC_PWR_FULL |-> !cmd_ready)
		else $error("command accepted outside full power");
	off_stay_a: assert property (@(posedge clk) disable iff (rst)
		pwr == TSC_PWR_OFF && !device_init_indication |=> pwr == TSC_PWR_OFF)
		else $error("left off state without init");
	shut_pwr_a: assert property (@(posedge clk) disable iff (rst)
		take_shutdown && !power_loss && !device_init_indication |=> $stable(pwr))
		else $error("shutdown moved power state");
	lp_idle_a: assert property (@(posedge clk) disable iff (rst)
		$rose(lp) |-> $past(iface_idle) && $past(!cmd_valid))
		else $error("low power entered while busy");
	ready_exit_a: assert property (@(posedge clk) disable iff (rst)
		lp && ready_req |-> ##[1:2] (!lp && ready_ack))
		else $error("ready request not answered in time");
	no_lp_start_a: assert property (@(posedge clk) disable iff (rst)
		!started |-> !lp)
		else $error("low power before startup");
	save_a: assert property (@(posedge clk) disable iff (rst)
		take_shutdown && cmd_flag |=> saved_valid && saved[0] == $past(mr[0]) &&
		(cmd_ready || pwr == TSC_PWR_OFF))
		else $error("state not saved on shutdown");
	void_a: assert property (@(posedge clk) disable iff (rst)
		take && cmd_alters_state && !take_shutdown |=> !saved_valid)
		else $error("saved state not voided");
	partial_a: assert property (@(posedge clk) disable iff (rst)
		take_test && !cmd_flag && !st_all_done && !st_failed && !device_init_indication |=>
		resp_valid && resp_code == `TSC_RC_TESTING)
		else $error("partial test answer wrong");
	full_wait_a: assert property (@(posedge clk) disable iff (rst)
		pend_full && !st_done |=> !resp_valid)
		else $error("full test answered early");
endmodule // tsc_state_ctrl
`default_nettype wire

// [verification/trust_module_state_control_tb.sv]
// Self-checking bench for the state control block
`timescale 1ns/1ps
`default_nettype none
`include "tsc_consts.svh"
module trust_module_state_control_tb;
	import tsc_pkg::*;
	localparam int TC = 2;
	localparam int TCY = 4;
	localparam int TOB = 8;
	logic clk, rst, wb_cyc, wb_stb, wb_we, wb_ack_o, init, ploss, strap, idle, rdy_req, rdy_ack;
	logic core_gate, lpc_pm, root_done, drtm_end, tfault, c_valid, c_flag, c_alt, c_ready;
	logic r_valid, h_go, h_flag, h_alt, h_done, lpc_pm_l;
	logic [7:0] wb_adr;
	logic [31:0] wb_dat, wb_dat_o, q;
	logic [255:0] root_val, drtm_val;
	logic [2:0] c_loc, h_loc;
	tsc_cmd_e c_kind, h_kind;
	tsc_rc_t r_code, h_code;
	int fails, checks_done, lat;
	// Second instance: one bus variant per device, so the strap needs its own
	tsc_state_ctrl #(.LPC_BUS(1'b1), .SPI_BUS(1'b0), .TIMEOUT_B_CYC(TOB), .TEST_COUNT(TC),
		.TEST_CYCLES(TCY)) DUT_LPC (
		.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
		.wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat), .wb_dat_o(),
		.wb_ack_o(), .device_init_indication(init), .power_loss(ploss),
		.bus_power_down_pin(strap), .iface_idle(idle), .ready_req(rdy_req), .ready_ack(),
		.core_gate(), .lpc_pm_enabled(lpc_pm_l), .hw_root_done(root_done),
		.hw_root_value(root_val), .drtm_end(drtm_end), .drtm_value(drtm_val),
		.test_fault(tfault), .cmd_valid(c_valid), .cmd_kind(c_kind), .cmd_flag(c_flag),
		.cmd_alters_state(c_alt), .cmd_locality(c_loc), .cmd_ready(),
		.resp_valid(), .resp_code());
	tsc_state_ctrl #(.TIMEOUT_B_CYC(TOB), .TEST_COUNT(TC), .TEST_CYCLES(TCY)) DUT (
		.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
		.wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .device_init_indication(init), .power_loss(ploss),
		.bus_power_down_pin(strap), .iface_idle(idle), .ready_req(rdy_req), .ready_ack(rdy_ack),
		.core_gate(core_gate), .lpc_pm_enabled(lpc_pm), .hw_root_done(root_done),
		.hw_root_value(root_val), .drtm_end(drtm_end), .drtm_value(drtm_val),
		.test_fault(tfault), .cmd_valid(c_valid), .cmd_kind(c_kind), .cmd_flag(c_flag),
		.cmd_alters_state(c_alt), .cmd_locality(c_loc), .cmd_ready(c_ready),
		.resp_valid(r_valid), .resp_code(r_code));
	tsc_host_model host (.clk(clk), .rst(rst), .go(h_go), .kind(h_kind), .flag(h_flag),
		.alters(h_alt), .locality(h_loc), .cmd_ready(c_ready), .resp_valid(r_valid),
		.resp_code(r_code), .cmd_valid(c_valid), .cmd_kind(c_kind), .cmd_flag(c_flag),
		.cmd_alters_state(c_alt), .cmd_locality(c_loc), .done(h_done), .code(h_code));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic hang(input int n, input int lim);
		if (n >= lim) begin
			chk(32'h0, 32'h1);
			summarize();
		end
	endtask
	// Classic cycle: request held until ack is sampled high
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_dat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		hang(n, 50);
		q = wb_dat_o;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge clk);
	endtask
	task automatic mr_chk(input int i, input int w, input logic [31:0] e);
		wb(1'b1, `TSC_ADR_MR_SEL, {16'h0000, 8'(w), 8'(i)});
		wb(1'b0, `TSC_ADR_MR_DATA, 32'h0000_0000);
		chk(q, e);
	endtask
	task automatic st_chk(input int b, input logic e);
		wb(1'b0, `TSC_ADR_STATUS, 32'h0000_0000);
		chk({31'h0, q[b]}, {31'h0, e});
	endtask
	// An unknown expected code means the answer is not judged
	task automatic cmd(input tsc_cmd_e k, input logic f, input logic a, input logic [2:0] l,
		input tsc_rc_t e);
		int n;
		n = 0;
		h_kind <= k;
		h_flag <= f;
		h_alt <= a;
		h_loc <= l;
		h_go <= 1'b1;
		@(posedge clk);
		h_go <= 1'b0;
		do begin
			@(posedge clk);
			n++;
		end while (h_done !== 1'b1 && n < 100);
		hang(n, 100);
		lat = n;
		if (!$isunknown(e)) chk({24'h0, h_code}, {24'h0, e});
	endtask
	task automatic pulse_init();
		init <= 1'b1;
		@(posedge clk);
		init <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	task automatic t_bus();
		wb(1'b0, 8'hF0, 32'h0000_0000);
		chk(q, 32'h0000_0000);
		wb(1'b1, `TSC_ADR_STATUS, 32'hFFFF_FFFF);
		wb(1'b1, `TSC_ADR_MR_SEL, 32'h0000_0305);
		wb(1'b0, `TSC_ADR_MR_SEL, 32'h0000_0000);
		chk(q, 32'h0000_0305);
		st_chk(`TSC_ST_STARTED, 1'b0);
		$display("test bus finished");
	endtask
	task automatic t_clear();
		cmd(TSC_CMD_STARTUP, 1'b0, 1'b0, 3'h3, `TSC_RC_SUCCESS);
		mr_chk(0, 0, 32'h0000_0003);
		for (int i = 1; i < 17; i++) mr_chk(i, 0, 32'h0000_0000);
		mr_chk(23, 7, 32'h0000_0000);
		for (int i = 17; i < 23; i++) mr_chk(i, i - 16, 32'hFFFF_FFFF);
		st_chk(`TSC_ST_PWR, 1'b0);
		$display("test clear finished");
	endtask
	task automatic t_rst_dyn();
		cmd(TSC_CMD_MR_RESET, 1'b0, 1'b0, 3'h2, `TSC_RC_SUCCESS);
		for (int i = 16; i < 24; i++) mr_chk(i, 0, (i > 16 && i < 20) ? '1 : '0);
		mr_chk(0, 0, 32'h0000_0003);
		drtm_val <= {8{32'h1234_5678}};
		drtm_end <= 1'b1;
		@(posedge clk);
		drtm_end <= 1'b0;
		mr_chk(17, 5, 32'h1234_5678);
		for (int i = 18; i < 23; i++) mr_chk(i, 0, 32'h0000_0000);
		mr_chk(0, 0, 32'h0000_0003);
		$display("test reset and dynamic finished");
	endtask
	task automatic t_save();
		cmd(TSC_CMD_SHUTDOWN, 1'b1, 1'b0, 3'h0, `TSC_RC_SUCCESS);
		st_chk(`TSC_ST_SAVED, 1'b1);
		st_chk(`TSC_ST_PWR, 1'b0);
		cmd(TSC_CMD_OTHER, 1'b0, 1'b1, 3'h0, `TSC_RC_SUCCESS);
		st_chk(`TSC_ST_SAVED, 1'b0);
		cmd(TSC_CMD_STARTUP, 1'b1, 1'b0, 3'h0, `TSC_RC_RESTORE_FAIL);
		cmd(TSC_CMD_STARTUP, 1'b0, 1'b0, 3'h2, `TSC_RC_SUCCESS);
		cmd(TSC_CMD_SHUTDOWN, 1'b1, 1'b0, 3'h0, `TSC_RC_SUCCESS);
		pulse_init();
		cmd(TSC_CMD_STARTUP, 1'b1, 1'b0, 3'h5, `TSC_RC_SUCCESS);
		mr_chk(0, 0, 32'h0000_0002);
		mr_chk(17, 0, 32'hFFFF_FFFF);
		$display("test save finished");
	endtask
	task automatic t_root();
		pulse_init();
		root_val <= {8{32'hA5A5_0F0F}};
		root_done <= 1'b1;
		@(posedge clk);
		root_done <= 1'b0;
		cmd(TSC_CMD_STARTUP, 1'b0, 1'b0, 3'h1, `TSC_RC_SUCCESS);
		mr_chk(0, 7, 32'hA5A5_0F0F);
		$display("test root finished");
	endtask
	task automatic t_test();
		pulse_init();
		cmd(TSC_CMD_SELF_TEST, 1'b0, 1'b0, 3'h0, `TSC_RC_TESTING);
		cmd(TSC_CMD_TEST_QUERY, 1'b0, 1'b0, 3'h0, `TSC_RC_TESTING);
		repeat (3 * TC * TCY) @(posedge clk);
		cmd(TSC_CMD_TEST_QUERY, 1'b0, 1'b0, 3'h0, `TSC_RC_SUCCESS);
		cmd(TSC_CMD_SELF_TEST, 1'b0, 1'b0, 3'h0, `TSC_RC_SUCCESS);
		cmd(TSC_CMD_SELF_TEST, 1'b1, 1'b0, 3'h0, `TSC_RC_SUCCESS);
		chk(32'(lat >= TC * TCY + 2), 32'h1);
		tfault <= 1'b1;
		cmd(TSC_CMD_SELF_TEST, 1'b1, 1'b0, 3'h0, `TSC_RC_FAILURE);
		tfault <= 1'b0;
		wb(1'b0, `TSC_ADR_TEST, 32'h0000_0000);
		chk(q & 32'h0000_00FF, 32'(`TSC_RC_FAILURE));
		$display("test self test finished");
	endtask
	task automatic t_lp();
		int n;
		n = 0;
		pulse_init();
		idle <= 1'b1;
		repeat (6) @(posedge clk);
		st_chk(`TSC_ST_LP, 1'b0);
		cmd(TSC_CMD_STARTUP, 1'b0, 1'b0, 3'h0, `TSC_RC_SUCCESS);
		repeat (6) @(posedge clk);
		st_chk(`TSC_ST_LP, 1'b1);
		chk({31'h0, core_gate}, 32'h1);
		rdy_req <= 1'b1;
		@(posedge clk);
		rdy_req <= 1'b0;
		do begin
			@(posedge clk);
			n++;
		end while (rdy_ack !== 1'b1 && n < TOB);
		chk(32'(n < TOB), 32'h1);
		idle <= 1'b0;
		cmd(TSC_CMD_TEST_QUERY, 1'b0, 1'b0, 3'h0, `TSC_RC_NEEDS_TEST);
		st_chk(`TSC_ST_LP, 1'b0);
		$display("test low power finished");
	endtask
	task automatic t_pwr();
		ploss <= 1'b1;
		@(posedge clk);
		ploss <= 1'b0;
		st_chk(`TSC_ST_PWR, 1'b1);
		chk({31'h0, c_ready}, 32'h0);
		rdy_req <= 1'b1;
		@(posedge clk);
		rdy_req <= 1'b0;
		st_chk(`TSC_ST_PWR, 1'b1);
		pulse_init();
		st_chk(`TSC_ST_PWR, 1'b0);
		chk({31'h0, c_ready}, 32'h1);
		$display("test power finished");
	endtask
	task automatic t_strap();
		chk({31'h0, lpc_pm}, 32'h0);
		chk({31'h0, lpc_pm_l}, 32'h1);
		strap <= 1'b1;
		pulse_init();
		chk({31'h0, lpc_pm_l}, 32'h0);
		strap <= 1'b0;
		pulse_init();
		chk({31'h0, lpc_pm_l}, 32'h1);
		$display("test strap finished");
	endtask
	initial begin
		fails = 0;
		checks_done = 0;
		{rst, init, ploss, root_done, drtm_end} <= 5'h1F & 5'h10;
		{wb_cyc, wb_stb, wb_we, strap, idle, rdy_req, tfault, h_go} <= 8'h00;
		{wb_adr, wb_dat, root_val, drtm_val} <= '0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_bus();
		t_clear();
		t_rst_dyn();
		t_save();
		t_root();
		t_test();
		t_lp();
		t_pwr();
		t_strap();
		summarize();
	end
endmodule // trust_module_state_control_tb
`default_nettype wire

// [verification/tsc_host_model.sv]
// Host side model issuing decoded commands and collecting the answers
`timescale 1ns/1ps
`default_nettype none
module tsc_host_model
	import tsc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic go,
	input wire tsc_pkg::tsc_cmd_e kind,
	input wire logic flag,
	input wire logic alters,
	input wire logic [2:0] locality,
	input wire logic cmd_ready,
	input wire logic resp_valid,
	input wire tsc_pkg::tsc_rc_t resp_code,
	output logic cmd_valid,
	output var tsc_pkg::tsc_cmd_e cmd_kind,
	output logic cmd_flag,
	output logic cmd_alters_state,
	output logic [2:0] cmd_locality,
	output logic done,
	output var tsc_pkg::tsc_rc_t code
);
	logic waiting;
	// Request and qualifiers held until the taking edge
	always_ff @(posedge clk) begin
		done <= 1'b0;
		if (rst) begin
			cmd_valid <= 1'b0;
			waiting <= 1'b0;
		end else if (go) begin
			cmd_valid <= 1'b1;
			cmd_kind <= kind;
			cmd_flag <= flag;
			cmd_alters_state <= alters;
			cmd_locality <= locality;
		end else if (cmd_valid && cmd_ready) begin
			cmd_valid <= 1'b0;
			waiting <= 1'b1;
			// Flipped so a stale qualifier never reads as current
			cmd_kind <= tsc_cmd_e'(~cmd_kind);
			cmd_flag <= ~cmd_flag;
			cmd_alters_state <= ~cmd_alters_state;
			cmd_locality <= ~cmd_locality;
		end else if (waiting && resp_valid) begin
			waiting <= 1'b0;
			done <= 1'b1;
			code <= resp_code;
		end
	end
endmodule // tsc_host_model
`default_nettype wire
